// ### dv/efp_enc_model.sv
// quadrature encoder model, lines hold position between moves
module efp_enc_model (
	// clock
	input wire logic       clk,
	// move request
	input wire logic       go,
	input wire logic       fwd,
	input wire logic [7:0] steps,
	input wire logic [7:0] per,
	// encoder pins
	output logic           a,
	output logic           b,
	output logic           busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_r = 2'h0;
	logic [7:0] left_r = 8'h00;
	logic [7:0] tmr_r = 8'h00;
	// a leads b when moving forward
	assign a = ph_r[0] ^ ph_r[1];
	assign b = ph_r[1];
	assign busy = left_r != 8'h00;
	// rising edge, away from the bench's falling-edge drive of go
	always @(posedge clk) begin
		if (go) begin
			left_r <= steps;
			tmr_r <= per;
		end else if (busy) begin
			if (tmr_r == 8'h00) begin
				ph_r <= fwd ? ph_r + 2'h1 : ph_r - 2'h1;
				left_r <= left_r - 8'h01;
				tmr_r <= per;
			end else
				tmr_r <= tmr_r - 8'h01;
		end
	end
endmodule

// ### dv/efp_props.sv
// port assertions for the conditioner
module efp_props #(
	parameter CW  = 32,
	parameter NAX = 3
) (
	// clock and reset
	input wire             clk,
	input wire             nrst,
	// watched ports
	input wire [2:0]       sp_mult,
	input wire [CW-1:0]    sp_cnt,
	input wire [3*CW-1:0]  ax_cnt,
	input wire [1:0]       pls_fmt,
	input wire [NAX-1:0]   cmd_req,
	input wire [NAX-1:0]   cmd_ready,
	input wire [NAX-1:0]   out_a,
	input wire [NAX-1:0]   out_b
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence hi8; out_a[0] [*8]; endsequence
	sequence pulse20; hi8 ##1 hi8 ##1 out_a[0] [*4] ##1 !out_a[0]; endsequence
	ready_drop_a: assert property (cmd_req[0] && cmd_ready[0] |=> !cmd_ready[0])
		else $error("ready stayed high after request");
	pulse_width_a: assert property ($rose(out_a[0]) && !pls_fmt[1] |-> pulse20)
		else $error("pulse not twenty cycles");
	pulse_gap_a: assert property ($fell(out_a[0]) && !pls_fmt[1] |-> !out_a[0] [*8])
		else $error("pulses too close");
	dir_hold_a: assert property (pls_fmt == 2'h0 && out_a[0] && $past(out_a[0]) |-> $stable(out_b[0]))
		else $error("direction moved in pulse");
	posneg_excl_a: assert property (pls_fmt == 2'h1 |-> !(out_a[0] && out_b[0]))
		else $error("both pulse lines high");
	fmt_idle_a: assert property (pls_fmt == 2'h3 && $past(pls_fmt) == 2'h3 |-> out_a == 0 && out_b == 0)
		else $error("outputs active in unused format");
	bad_mult_a: assert property ($past(sp_mult) == 3'h3 && $past(sp_mult, 2) == 3'h3 |-> $stable(sp_cnt))
		else $error("count moved with bad multiple");
	sp_step_a: assert property ($changed(sp_cnt) |-> sp_cnt - $past(sp_cnt) == 1 || $past(sp_cnt) - sp_cnt == 1)
		else $error("spindle count jumped");
	ax_step_a: assert property ($changed(ax_cnt[CW-1:0]) |-> ax_cnt[CW-1:0] - $past(ax_cnt[CW-1:0]) == 1 || $past(ax_cnt[CW-1:0]) - ax_cnt[CW-1:0] == 1)
		else $error("axis count jumped");
endmodule

bind efp_conditioner efp_props #(.CW(CW), .NAX(NAX)) efp_props_i (.clk(clk), .nrst(nrst),
	.sp_mult(sp_mult), .sp_cnt(sp_cnt), .ax_cnt(ax_cnt), .pls_fmt(pls_fmt), .cmd_req(cmd_req),
	.cmd_ready(cmd_ready), .out_a(out_a), .out_b(out_b));

// ### dv/encoder_feedback_pulse_conditioner_tb.sv
// self-checking bench for the encoder feedback and pulse conditioner
`include "efp_regs.vh"
module encoder_feedback_pulse_conditioner_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, sgo = 1'b0, xgo = 1'b0, edir = 1'b1, sa, sb, xa, xb, sbz, xbz;
	logic [7:0] esteps = 8'h00, eper = 8'h00, pls_div = `EFP_DIV_RST;
	logic [2:0] sp_mult = `EFP_MULT_RST, cmd_req = 3'h0, cmd_dir = 3'h7, cmd_ready, out_a, out_b;
	logic sp_dir_inv = 1'b0, ax_dir_inv = 1'b0, lin_feed = 1'b0, rev_en = 1'b0;
	logic [1:0] sp_filt_sel = `EFP_FILT_RST, ax_filt_sel = `EFP_FILT_RST, pls_fmt = `EFP_FMT_RST;
	logic [19:0] res_num = `EFP_RES_NUM_RST;
	logic [15:0] res_den = `EFP_RES_DEN_RST;
	logic signed [15:0] backlash = `EFP_BL_RST;
	logic [11:0] off_fwd = 12'h000, off_rev = 12'h000, off_time_ms = 12'h000, acc_ms = 12'h001;
	logic [31:0] sp_cnt, sp_pos;
	logic [95:0] ax_cnt;
	int mismatches = 0, num_checks = 0;
	efp_enc_model sp_i (.clk(clk), .go(sgo), .fwd(edir), .steps(esteps), .per(eper),
		.a(sa), .b(sb), .busy(sbz));
	efp_enc_model ax_i (.clk(clk), .go(xgo), .fwd(edir), .steps(esteps), .per(eper),
		.a(xa), .b(xb), .busy(xbz));
	// 1 ms shortened to 1000 clk so offset windows stay short
	efp_conditioner #(.CYC_PER_MS(1000)) efp_conditioner_i (.clk(clk), .nrst(nrst),
		.sp_a(sa), .sp_b(sb), .ax_a({3{xa}}), .ax_b({3{xb}}), .sp_mult(sp_mult),
		.sp_dir_inv(sp_dir_inv), .sp_filt_sel(sp_filt_sel), .ax_dir_inv(ax_dir_inv),
		.ax_filt_sel(ax_filt_sel), .res_num(res_num), .res_den(res_den), .sp_cnt(sp_cnt),
		.ax_cnt(ax_cnt), .sp_pos(sp_pos), .pls_div(pls_div), .pls_fmt(pls_fmt),
		.lin_feed(lin_feed), .backlash(backlash), .rev_en(rev_en), .off_fwd(off_fwd),
		.off_rev(off_rev), .off_time_ms(off_time_ms), .acc_ms(acc_ms), .cmd_req(cmd_req),
		.cmd_dir(cmd_dir), .cmd_ready(cmd_ready), .out_a(out_a), .out_b(out_b));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// moves the spindle or all axes, then lets filter and decode settle
	task automatic move(input logic sp, input logic [7:0] n, input logic [7:0] p);
		int k;
		esteps = n;
		eper = p;
		sgo = sp;
		xgo = !sp;
		@(negedge clk);
		sgo = 1'b0;
		xgo = 1'b0;
		for (k = 0; k < 3000 && (k < 2 || sbz || xbz); k++) @(negedge clk);
		if (k == 3000) begin
			mismatches++;
			wrap_up();
		end
		repeat (400) @(negedge clk);
	endtask
	task automatic t_spindle;
		int mt[4] = '{4, 2, 1, 3}, ex[4] = '{8, -4, 2, 0}, fc[5] = '{0, 1, 2, 3, 2};
		int fp[5] = '{60, 60, 60, 60, 20}, fe[5] = '{4, 4, 4, 0, 0};
		logic [31:0] c0;
		for (int i = 0; i < 4; i++) begin
			sp_mult = mt[i][2:0];
			sp_dir_inv = i == 1;
			c0 = sp_cnt;
			move(1'b1, 8'h08, 8'h3c);
			chk("spindle count", sp_cnt - c0, ex[i]);
		end
		sp_mult = 3'h4;
		sp_dir_inv = 1'b0;
		for (int i = 0; i < 5; i++) begin
			sp_filt_sel = fc[i][1:0];
			c0 = sp_cnt;
			move(1'b1, 8'h04, fp[i][7:0]);
			chk("filtered count", sp_cnt - c0, fe[i]);
		end
		res_num = 20'h00003;
		res_den = 16'h0002;
		repeat (200) @(negedge clk);
		chk("position", sp_pos, 27);
		$display("spindle feedback done");
	endtask
	task automatic t_axes;
		logic [95:0] c0;
		int e;
		for (int i = 0; i < 4; i++) begin
			ax_filt_sel = i[1:0];
			ax_dir_inv = i[0];
			e = i == 3 ? 0 : (i[0] ? -4 : 4);
			c0 = ax_cnt;
			move(1'b0, 8'h04, 8'h3c);
			for (int j = 0; j < 3; j++)
				chk("axis count", ax_cnt[32*j+:32] - c0[32*j+:32], e);
		end
		$display("axis feedback done");
	endtask
	// one request on every axis, counts pulses seen on axis 0
	task automatic cmd(input logic d, input int ea, input int eb, input int gap);
		int na = 0, nb = 0, k, t0 = 0, dt = 0, idle = 0;
		logic pa = out_a[0], pb = out_b[0];
		cmd_dir = {3{d}};
		cmd_req = 3'h7;
		@(negedge clk);
		cmd_req = 3'h0;
		// stay until ready has held 40 cycles so the last pulse ends before a format change
		for (k = 0; k < 6000 && idle < 40; k++) begin
			@(negedge clk);
			if (out_a[0] && !pa) begin
				na++;
				dt = k - t0;
				t0 = k;
			end
			nb += out_b[0] && !pb;
			pa = out_a[0];
			pb = out_b[0];
			idle = (k >= 3 && cmd_ready === 3'h7) ? idle + 1 : 0;
		end
		if (k == 6000) begin
			mismatches++;
			wrap_up();
		end
		chk("pulses", na, ea);
		if (pls_fmt == 2'h0)
			chk("direction", out_b[0], d);
		else
			chk("second line", nb, eb);
		if (gap != 0)
			chk("pulse spacing", dt, gap);
	endtask
	task automatic t_command;
		pls_div = 8'h01;
		pls_fmt = 2'h2;
		// one phase step up from 0 raises the second line only
		cmd(1'b1, 0, 1, 0);
		pls_fmt = 2'h0;
		cmd(1'b1, 1, 0, 0);
		pls_fmt = 2'h1;
		rev_en = 1'b1;
		off_rev = 12'h003;
		off_fwd = 12'h002;
		cmd(1'b0, 0, 4, 0);
		cmd(1'b1, 3, 0, 0);
		rev_en = 1'b0;
		pls_fmt = 2'h0;
		lin_feed = 1'b1;
		backlash = 16'sh0002;
		pls_div = 8'h02;
		cmd(1'b0, 3, 0, 80);
		lin_feed = 1'b0;
		pls_fmt = 2'h3;
		cmd(1'b0, 0, 0, 0);
		pls_fmt = 2'h0;
		rev_en = 1'b1;
		off_fwd = 12'h040;
		off_time_ms = 12'h001;
		acc_ms = 12'h002;
		// 1 ms window holds 25 base-rate slots, rest of the lump is dropped
		cmd(1'b1, 26, 0, 0);
		rev_en = 1'b0;
		$display("command pulses done");
	endtask
	initial begin
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		chk("ready after reset", cmd_ready, 3'h7);
		t_spindle();
		t_axes();
		t_command();
		wrap_up();
	end
endmodule

// ### verilog/efp_conditioner.v
// encoder feedback conditioning and command pulse shaping for four feedback and three command axes
// What this block does
// [RULE1] spindle count multiple 1, 2 or 4
// [RULE2] spindle direction 0 positive, 1 inverted
// [RULE3] spindle filter code selects 500/750/1000/342 kHz
// [RULE4] axis direction 0 forward, 1 reversed
// [RULE5] axis filters use same frequency codes
// [RULE6] pulse rate is 2500 kHz divided by n
// [RULE7] negative-to-positive reversal injects forward offset
// [RULE8] positive-to-negative reversal injects reverse offset
// [RULE9] offset pulses fit in offset time window
// [RULE10] offset emitted as lump after reversal
// [RULE11] enable bit gates the reversal offset
// [RULE12] counts scaled by numerator over denominator; code scales only the spindle count, into sp_pos
// [RULE13] signed backlash within 9.999 mm on reversal
// [RULE14] output format pulse-dir, pos-neg or quadrature
// [RULE15] filtered quadrature decoded into count events
`include "efp_regs.vh"

module efp_conditioner #(
	parameter CYC_PER_MS = `EFP_CYC_PER_MS,
	parameter NAX        = 3,
	parameter CW         = 32
) (
	// clock and reset
	input  wire                clk,
	input  wire                nrst,
	// encoder pins, spindle and X/Y/Z
	input  wire                sp_a,
	input  wire                sp_b,
	input  wire [2:0]          ax_a,
	input  wire [2:0]          ax_b,
	// feedback configuration
	input  wire [2:0]          sp_mult,
	input  wire                sp_dir_inv,
	input  wire [1:0]          sp_filt_sel,
	input  wire                ax_dir_inv,
	input  wire [1:0]          ax_filt_sel,
	input  wire [19:0]         res_num,
	input  wire [15:0]         res_den,
	// feedback results
	output wire [CW-1:0]       sp_cnt,
	output wire [3*CW-1:0]     ax_cnt,
	output reg  [CW-1:0]       sp_pos,
	// command configuration
	input  wire [7:0]          pls_div,
	input  wire [1:0]          pls_fmt,
	input  wire                lin_feed,
	input  wire signed [15:0]  backlash,
	input  wire                rev_en,
	input  wire [11:0]         off_fwd,
	input  wire [11:0]         off_rev,
	input  wire [11:0]         off_time_ms,
	input  wire [11:0]         acc_ms,
	// command requests, one step per accepted request, plus any backlash and offset pulses on a reversal
	input  wire [NAX-1:0]      cmd_req,
	input  wire [NAX-1:0]      cmd_dir,
	output wire [NAX-1:0]      cmd_ready,
	// command pins
	output wire [NAX-1:0]      out_a,
	output wire [NAX-1:0]      out_b
);

	localparam integer TH0 = `EFP_FILT_CYC(`EFP_FILT0_KHZ);
	localparam integer TH1 = `EFP_FILT_CYC(`EFP_FILT1_KHZ);
	localparam integer TH2 = `EFP_FILT_CYC(`EFP_FILT2_KHZ);
	localparam integer TH3 = `EFP_FILT_CYC(`EFP_FILT3_KHZ);
	localparam integer BASE = `EFP_BASE_CYC;
	localparam integer PW   = `EFP_PW_CYC;

	// ---------------- feedback input filters ----------------
	// bit order: 0 sp_a, 1 sp_b, 2..4 ax_a, 5..7 ax_b
	wire [7:0] raw_in = {ax_b, ax_a, sp_b, sp_a};
	wire [7:0] filt;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_filt
			reg       s1_r;
			reg       s2_r;
			reg       f_r;
			reg [7:0] cnt_r;
			wire [1:0] sel = (gi < 2) ? sp_filt_sel : ax_filt_sel;
			reg  [7:0] th;
			always @* begin
				case (sel)  // [RULE3] [RULE5]
				2'h0: th = TH0[7:0];
				2'h1: th = TH1[7:0];
				2'h2: th = TH2[7:0];
				2'h3: th = TH3[7:0];
				default: th = TH0[7:0];
				endcase
			end
			// level must hold half a pass period before it is believed
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					f_r   <= 1'b0;
					cnt_r <= 8'h00;
				end else begin
					s1_r <= raw_in[gi];
					s2_r <= s1_r;
					if (s2_r == f_r) begin
						cnt_r <= 8'h00;
					end else if (cnt_r >= th - 8'h01) begin
						f_r   <= s2_r;
						cnt_r <= 8'h00;
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
			end
			assign filt[gi] = f_r;
		end
	endgenerate

	// ---------------- quadrature decode and counters ----------------
	wire [CW-1:0] cnt_w [0:3];

	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_dec
			reg          ap_r;
			reg          bp_r;
			reg [CW-1:0] cnt_r;
			wire a = (gi == 0) ? filt[0] : filt[1 + gi];
			wire b = (gi == 0) ? filt[1] : filt[4 + gi];
			wire [2:0] mult = (gi == 0) ? sp_mult : `EFP_MULT_X4;
			wire inv = (gi == 0) ? sp_dir_inv : ax_dir_inv;
			reg  ev;
			reg  up;
			always @* begin
				ev = 1'b0;
				up = 1'b0;
				case (mult)  // [RULE1] [RULE15]
				`EFP_MULT_X1: begin
					ev = a & ~ap_r;
					up = ~b;
				end
				`EFP_MULT_X2: begin
					ev = a ^ ap_r;
					up = a ^ b;
				end
				`EFP_MULT_X4: begin
					// same sense as x1/x2: a leading b counts up
					ev = (a ^ ap_r) | (b ^ bp_r);
					up = a ^ bp_r;
				end
				default: begin
					ev = 1'b0;
					up = 1'b0;
				end
				endcase
			end
			// invert sense per direction setting
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					ap_r  <= 1'b0;
					bp_r  <= 1'b0;
					cnt_r <= {CW{1'b0}};
				end else begin
					ap_r <= a;
					bp_r <= b;
					if (ev) begin
						if (up ^ inv)  // [RULE2] [RULE4]
							cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
						else
							cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
					end
				end
			end
			assign cnt_w[gi] = cnt_r;
		end
	endgenerate

	assign sp_cnt = cnt_w[0];
	assign ax_cnt = {cnt_w[3], cnt_w[2], cnt_w[1]};

	// ---------------- spindle count to position scaling ----------------
	// one shared serial divider: 57 cycles per update (load plus 56 steps) saves a wide array divider
	reg        dv_busy_r;
	reg [5:0]  dv_step_r;
	reg [55:0] dv_q_r;
	reg [16:0] dv_rem_r;
	reg        dv_neg_r;
	wire [CW-1:0] sp_mag = sp_cnt[CW-1] ? (~sp_cnt + {{(CW-1){1'b0}}, 1'b1}) : sp_cnt;
	wire [51:0]   prod   = sp_mag * res_num;
	wire [16:0]   dv_t   = {dv_rem_r[15:0], dv_q_r[55]};
	wire          dv_ge  = dv_t >= {1'b0, res_den};

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dv_busy_r <= 1'b0;
			dv_step_r <= 6'h00;
			dv_q_r    <= 56'h0;
			dv_rem_r  <= 17'h0;
			dv_neg_r  <= 1'b0;
			sp_pos    <= {CW{1'b0}};
		end else if (!dv_busy_r) begin
			if (res_den != 16'h0000) begin  // [RULE12]
				dv_busy_r <= 1'b1;
				dv_step_r <= 6'h00;
				dv_q_r    <= {4'h0, prod};
				dv_rem_r  <= 17'h0;
				dv_neg_r  <= sp_cnt[CW-1];
			end
		end else begin
			dv_rem_r  <= dv_ge ? (dv_t - {1'b0, res_den}) : dv_t;
			dv_q_r    <= {dv_q_r[54:0], dv_ge};
			dv_step_r <= dv_step_r + 6'h01;
			if (dv_step_r == 6'h37) begin
				dv_busy_r <= 1'b0;
				if (dv_neg_r)
					sp_pos <= ~{dv_q_r[CW-2:0], dv_ge} + {{(CW-1){1'b0}}, 1'b1};
				else
					sp_pos <= {dv_q_r[CW-2:0], dv_ge};
			end
		end
	end

	// ---------------- command rate ticks ----------------
	reg [7:0]  base_cnt_r;
	reg        base_tick_r;
	reg [7:0]  div_cnt_r;
	reg        cmd_tick_r;
	wire [7:0] div_eff = (pls_div == 8'h00) ? 8'h01 : pls_div;

	// base tick at 2500 kHz, command tick every n base ticks
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			base_cnt_r  <= 8'h00;
			base_tick_r <= 1'b0;
			div_cnt_r   <= 8'h00;
			cmd_tick_r  <= 1'b0;
		end else begin
			base_tick_r <= 1'b0;
			cmd_tick_r  <= 1'b0;
			if (base_cnt_r == BASE[7:0] - 8'h01) begin
				base_cnt_r  <= 8'h00;
				base_tick_r <= 1'b1;
				if (div_cnt_r >= div_eff - 8'h01) begin  // [RULE6]
					div_cnt_r  <= 8'h00;
					cmd_tick_r <= 1'b1;
				end else begin
					div_cnt_r <= div_cnt_r + 8'h01;
				end
			end else begin
				base_cnt_r <= base_cnt_r + 8'h01;
			end
		end
	end

	// backlash held within its legal band
	wire signed [15:0] bl_c = (backlash > `EFP_BL_MAX) ? `EFP_BL_MAX :
		(backlash < -`EFP_BL_MAX) ? -`EFP_BL_MAX : backlash;
	wire [31:0] win_ms = (off_time_ms != 12'h000) ? {20'h0, off_time_ms} : {20'h0, acc_ms};
	wire [31:0] win_ld = win_ms * CYC_PER_MS;

	// ---------------- per-axis command generators ----------------
	generate
		for (gi = 0; gi < NAX; gi = gi + 1) begin : g_cmd
			reg               dirl_r;
			reg signed [15:0] pend_r;
			reg [11:0]        off_r;
			reg               odir_r;
			reg [31:0]        win_r;
			reg               rdy_r;
			reg [7:0]         pw_r;
			reg               pls_r;
			reg               edir_r;
			reg [1:0]         ph_r;
			reg               oa_r;
			reg               ob_r;
			wire acc = cmd_req[gi] & rdy_r;
			wire rev = acc & (cmd_dir[gi] != dirl_r);
			wire signed [15:0] step = cmd_dir[gi] ? 16'sh0001 : -16'sh0001;
			wire signed [15:0] blv  = cmd_dir[gi] ? bl_c : -bl_c;
			wire emit_off = (pw_r == 8'h00) & base_tick_r & (off_r != 12'h000) &
				(win_r != 32'h0);
			wire emit_cmd = (pw_r == 8'h00) & cmd_tick_r & ~emit_off & (pend_r != 16'sh0000);
			wire edir = emit_off ? odir_r : ~pend_r[15];
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					dirl_r <= 1'b1;
					pend_r <= 16'sh0000;
					off_r  <= 12'h000;
					odir_r <= 1'b1;
					win_r  <= 32'h0;
					rdy_r  <= 1'b0;
					pw_r   <= 8'h00;
					pls_r  <= 1'b0;
					edir_r <= 1'b1;
					ph_r   <= 2'h0;
					oa_r   <= 1'b0;
					ob_r   <= 1'b0;
				end else begin
					rdy_r <= (pend_r == 16'sh0000) & (off_r == 12'h000) & ~acc;
					if (acc) begin
						dirl_r <= cmd_dir[gi];
						if (rev & lin_feed)
							pend_r <= pend_r + step + blv;  // [RULE13]
						else
							pend_r <= pend_r + step;
					end else if (emit_cmd) begin
						pend_r <= pend_r - (pend_r[15] ? -16'sh0001 : 16'sh0001);
					end
					if (rev & rev_en) begin  // [RULE11]
						// dir 1 after 0 is neg-to-pos
						off_r  <= cmd_dir[gi] ? off_fwd : off_rev;  // [RULE7] [RULE8]
						odir_r <= cmd_dir[gi];
						win_r  <= win_ld;
					end else begin
						if (win_r != 32'h0)
							win_r <= win_r - 32'h1;
						if (win_r == 32'h1)
							off_r <= 12'h000;  // [RULE9]
						else if (emit_off)
							off_r <= off_r - 12'h001;  // [RULE10]
					end
					// offset lump goes out at base rate ahead of queued motion
					if (emit_off | emit_cmd) begin
						pw_r   <= PW[7:0];
						pls_r  <= 1'b1;
						edir_r <= edir;
						ph_r   <= edir ? ph_r + 2'h1 : ph_r - 2'h1;
					end else if (pw_r != 8'h00) begin
						pw_r <= pw_r - 8'h01;
						if (pw_r == 8'h01)
							pls_r <= 1'b0;
					end
					case (pls_fmt)  // [RULE14]
					`EFP_FMT_PLS_DIR: begin
						oa_r <= pls_r;
						ob_r <= edir_r;
					end
					`EFP_FMT_POS_NEG: begin
						oa_r <= pls_r & edir_r;
						ob_r <= pls_r & ~edir_r;
					end
					`EFP_FMT_AB: begin
						oa_r <= ph_r[1];
						ob_r <= ph_r[1] ^ ph_r[0];
					end
					default: begin
						oa_r <= 1'b0;
						ob_r <= 1'b0;
					end
					endcase
				end
			end
			assign cmd_ready[gi] = rdy_r;
			assign out_a[gi]     = oa_r;
			assign out_b[gi]     = ob_r;
		end
	endgenerate

endmodule

// ### verilog/efp_regs.vh
// constants for the encoder feedback and pulse conditioner
`ifndef EFP_REGS_VH
`define EFP_REGS_VH

// system clock
`define EFP_CLK_KHZ       100000
`define EFP_CYC_PER_MS    100000

// spindle encoder multiple codes and reset value
`define EFP_MULT_X1       3'h1
`define EFP_MULT_X2       3'h2
`define EFP_MULT_X4       3'h4
`define EFP_MULT_RST      3'h4

// direction settings
`define EFP_DIR_POS       1'h0
`define EFP_DIR_NEG       1'h1

// filter pass frequencies in kHz for codes 0..3, reset code
`define EFP_FILT0_KHZ     500
`define EFP_FILT1_KHZ     750
`define EFP_FILT2_KHZ     1000
`define EFP_FILT3_KHZ     342
`define EFP_FILT_RST      2'h0
// stable time in cycles: half a period at the pass frequency
`define EFP_FILT_CYC(k)   (`EFP_CLK_KHZ / (2 * (k)))

// command pulse base rate and divisor
`define EFP_BASE_KHZ      2500
`define EFP_BASE_CYC      (`EFP_CLK_KHZ / `EFP_BASE_KHZ)
`define EFP_PW_CYC        (`EFP_BASE_CYC / 2)
`define EFP_DIV_RST       8'h05

// command output formats
`define EFP_FMT_PLS_DIR   2'h0
`define EFP_FMT_POS_NEG   2'h1
`define EFP_FMT_AB        2'h2
`define EFP_FMT_RST       2'h0

// resolution reset values
`define EFP_RES_NUM_RST   20'h57e40
`define EFP_RES_DEN_RST   16'h1000

// backlash limit, 9.999 mm in micrometre pulses
`define EFP_BL_MAX        16'sh270f
`define EFP_BL_RST        16'sh0000

`endif
